// file: logic/eepw_host.sv
// Host-side controller that drives a page-write EEPROM over its parallel pins
`timescale 1ns/1ns
module eepw_host #(
  parameter logic [eepw_pkg::CNT_W-1:0] WINDOW_CYC  = eepw_pkg::WINDOW_CYC,
  parameter logic [eepw_pkg::CNT_W-1:0] PROG_CYC    = eepw_pkg::PROG_CYC,
  parameter logic [eepw_pkg::CNT_W-1:0] ER_PULS_CYC = eepw_pkg::ER_PULS_CYC
) (
  // Clock and reset
  input  wire logic                 CORE_CLK_I,
  input  wire logic                 RST_I,
  // User request
  input  wire logic                 REQ_VALID_I,
  input  wire eepw_pkg::eepw_req_s  REQ_I,
  output logic                      REQ_RDY_O,
  // User answer
  output logic                      RSP_VALID_O,
  output logic [7:0]                RSP_DATA_O,
  output logic                      BUSY_O,
  // Device pins
  input  wire logic [7:0]           EE_DATA_I,
  output eepw_pkg::eepw_pins_s      EE_PINS_O
);

  localparam logic [eepw_pkg::CNT_W-1:0] GAP_LIMIT =
    eepw_pkg::CNT_W'(WINDOW_CYC - eepw_pkg::WP_CYC - eepw_pkg::WPH_CYC - 2);

  eepw_pkg::eepw_state_e           state;
  logic [eepw_pkg::CNT_W-1:0]      cnt;
  logic [3:0]                      cmd_left;
  logic [3:0]                      seq_idx;
  logic [12:0]                     w_addr;
  logic [7:0]                      w_data;
  logic [6:0]                      page;
  logic                            page_set;
  logic                            done;
  logic [6:0]                      nbytes;
  logic                            more_ok;
  logic                            take_more;

  function automatic logic at_end(input logic [eepw_pkg::CNT_W-1:0] c,
                                  input logic [eepw_pkg::CNT_W-1:0] len);
    at_end = (c == len - 1'b1);
  endfunction

  // Continue the page only inside the window and on the same page
  always_comb begin
    more_ok = (state == eepw_pkg::ST_GAP) && !done && (nbytes < eepw_pkg::PAGE_BYTES)
           && (cnt < GAP_LIMIT)
           && (!page_set || REQ_I.addr[12:6] == page);
    take_more = more_ok && REQ_VALID_I && REQ_I.op == eepw_pkg::OP_WRITE;
    REQ_RDY_O = (state == eepw_pkg::ST_IDLE) || (more_ok && REQ_I.op == eepw_pkg::OP_WRITE);
  end

  assign BUSY_O = (state != eepw_pkg::ST_IDLE);

  // Sequencer
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state    <= eepw_pkg::ST_IDLE;
      cnt      <= '0;
      cmd_left <= 4'h0;
      seq_idx  <= 4'h0;
      w_addr   <= 13'h0000;
      w_data   <= 8'h00;
    end else begin
      unique case (state)
        eepw_pkg::ST_IDLE: begin
          cnt <= '0;
          if (REQ_VALID_I) begin
            w_addr   <= REQ_I.addr;
            w_data   <= REQ_I.data;
            cmd_left <= 4'h0;
            unique case (REQ_I.op)
              eepw_pkg::OP_READ:  state <= eepw_pkg::ST_READ;
              eepw_pkg::OP_WRITE: state <= eepw_pkg::ST_WR_PULSE;
              eepw_pkg::OP_LOCK_ON: begin
                {w_addr, w_data} <= eepw_pkg::SEQ_TAB[eepw_pkg::SEQ_ON_FIRST];
                seq_idx  <= 4'(eepw_pkg::SEQ_ON_FIRST);
                cmd_left <= eepw_pkg::SEQ_ON_LEN;
                state    <= eepw_pkg::ST_WR_PULSE;
              end
              eepw_pkg::OP_LOCK_OFF: begin
                {w_addr, w_data} <= eepw_pkg::SEQ_TAB[eepw_pkg::SEQ_OFF_FIRST];
                seq_idx  <= 4'(eepw_pkg::SEQ_OFF_FIRST);
                cmd_left <= eepw_pkg::SEQ_OFF_LEN;
                state    <= eepw_pkg::ST_WR_PULSE;
              end
              eepw_pkg::OP_ERASE: state <= eepw_pkg::ST_ER_SETUP;
              default:            state <= eepw_pkg::ST_IDLE;
            endcase
          end
        end
        eepw_pkg::ST_READ: begin
          cnt <= cnt + 1'b1;
          if (cnt == eepw_pkg::RD_CYC) begin
            cnt   <= '0;
            state <= eepw_pkg::ST_RD_FLOAT;
          end
        end
        // Let the part release the bus before anyone drives it again
        eepw_pkg::ST_RD_FLOAT: begin
          cnt <= cnt + 1'b1;
          if (at_end(cnt, eepw_pkg::DF_CYC)) begin
            state <= eepw_pkg::ST_IDLE;
          end
        end
        eepw_pkg::ST_WR_PULSE: begin
          cnt <= cnt + 1'b1;
          if (at_end(cnt, eepw_pkg::WP_CYC)) begin
            cnt   <= '0;
            state <= eepw_pkg::ST_WR_HIGH;
          end
        end
        eepw_pkg::ST_WR_HIGH: begin
          cnt <= cnt + 1'b1;
          if (at_end(cnt, eepw_pkg::WPH_CYC)) begin
            cnt <= '0;
            if (cmd_left > 4'h1) begin
              cmd_left         <= cmd_left - 4'h1;
              seq_idx          <= seq_idx + 4'h1;
              {w_addr, w_data} <= eepw_pkg::SEQ_TAB[seq_idx + 4'h1];
              state            <= eepw_pkg::ST_WR_PULSE;
            end else begin
              cmd_left <= 4'h0;
              state    <= eepw_pkg::ST_GAP;
            end
          end
        end
        // The part only knows a page is complete when its window runs out
        eepw_pkg::ST_GAP: begin
          cnt <= cnt + 1'b1;
          if (take_more) begin
            cnt    <= '0;
            w_addr <= REQ_I.addr;
            w_data <= REQ_I.data;
            state  <= eepw_pkg::ST_WR_PULSE;
          end else if (at_end(cnt, WINDOW_CYC)) begin
            cnt   <= '0;
            state <= eepw_pkg::ST_WAIT;
          end
        end
        // No polling: a fixed wait is simpler and locked writes behave the same
        eepw_pkg::ST_WAIT: begin
          cnt <= cnt + 1'b1;
          if (at_end(cnt, PROG_CYC)) begin
            state <= eepw_pkg::ST_IDLE;
          end
        end
        eepw_pkg::ST_ER_SETUP: begin
          cnt <= cnt + 1'b1;
          if (at_end(cnt, eepw_pkg::ER_SU_CYC)) begin
            cnt   <= '0;
            state <= eepw_pkg::ST_ER_PULSE;
          end
        end
        eepw_pkg::ST_ER_PULSE: begin
          cnt <= cnt + 1'b1;
          if (at_end(cnt, ER_PULS_CYC)) begin
            cnt   <= '0;
            state <= eepw_pkg::ST_ER_HOLD;
          end
        end
        eepw_pkg::ST_ER_HOLD: begin
          cnt <= cnt + 1'b1;
          if (at_end(cnt, eepw_pkg::ER_SU_CYC)) begin
            state <= eepw_pkg::ST_IDLE;
          end
        end
        default: state <= eepw_pkg::ST_IDLE;
      endcase
    end
  end

  // Page bookkeeping
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      page     <= 7'h00;
      page_set <= 1'b0;
      done     <= 1'b0;
      nbytes   <= 7'h00;
    end else if (state == eepw_pkg::ST_IDLE && REQ_VALID_I) begin
      page     <= REQ_I.addr[12:6];
      page_set <= (REQ_I.op == eepw_pkg::OP_WRITE);
      done     <= REQ_I.last;
      nbytes   <= (REQ_I.op == eepw_pkg::OP_WRITE) ? 7'h01 : 7'h00;
    end else if (take_more) begin
      page     <= REQ_I.addr[12:6];
      page_set <= 1'b1;
      done     <= REQ_I.last;
      nbytes   <= nbytes + 7'h01;
    end
  end

  // Pins, one cycle behind the state so every width is whole
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      EE_PINS_O <= '{addr: 13'h0000, dout: 8'h00, dout_oe_n: 1'b1, ce_n: 1'b1,
                     oe_n: 1'b1, we_n: 1'b1, erase_hv: 1'b0};
    end else begin
      EE_PINS_O.addr      <= w_addr;
      EE_PINS_O.dout      <= w_data;
      EE_PINS_O.dout_oe_n <= !(state == eepw_pkg::ST_WR_PULSE || state == eepw_pkg::ST_WR_HIGH);
      EE_PINS_O.ce_n      <= !(state == eepw_pkg::ST_WR_PULSE || state == eepw_pkg::ST_READ
                             || state == eepw_pkg::ST_ER_SETUP || state == eepw_pkg::ST_ER_PULSE
                             || state == eepw_pkg::ST_ER_HOLD);
      EE_PINS_O.oe_n      <= (state != eepw_pkg::ST_READ);
      EE_PINS_O.we_n      <= !(state == eepw_pkg::ST_WR_PULSE
                             || state == eepw_pkg::ST_ER_PULSE);
      EE_PINS_O.erase_hv  <= (state == eepw_pkg::ST_ER_SETUP || state == eepw_pkg::ST_ER_PULSE
                             || state == eepw_pkg::ST_ER_HOLD);
    end
  end

  // Read answer
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      RSP_VALID_O <= 1'b0;
      RSP_DATA_O  <= 8'h00;
    end else begin
      RSP_VALID_O <= (state == eepw_pkg::ST_READ) && (cnt == eepw_pkg::RD_CYC);
      if (state == eepw_pkg::ST_READ && cnt == eepw_pkg::RD_CYC) begin
        RSP_DATA_O <= EE_DATA_I;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  // Checked on the pins, so a slip between request and pin path shows too
  property p_page_same;
    $fell(EE_PINS_O.we_n) && !EE_PINS_O.erase_hv && cmd_left == 4'h0 && page_set
      |-> EE_PINS_O.addr[12:6] == page;
  endproperty
  a_page_same: assert property (p_page_same) else $error("page bits changed in a load");

  property p_gate_high;
    !EE_PINS_O.we_n && !EE_PINS_O.ce_n && !EE_PINS_O.erase_hv
      |-> EE_PINS_O.oe_n && !EE_PINS_O.dout_oe_n;
  endproperty
  a_gate_high: assert property (p_gate_high) else $error("gate low during write");

  property p_window;
    $past(state) == eepw_pkg::ST_GAP && state == eepw_pkg::ST_WR_PULSE
      |-> $past(cnt) < GAP_LIMIT;
  endproperty
  a_window: assert property (p_window) else $error("byte loaded past window");

  property p_page_len;
    nbytes <= eepw_pkg::PAGE_BYTES;
  endproperty
  a_page_len: assert property (p_page_len) else $error("more than a page loaded");

  property p_prog_wait;
    $past(state) == eepw_pkg::ST_WAIT && state != eepw_pkg::ST_WAIT
      |-> $past(cnt) == PROG_CYC - 1'b1;
  endproperty
  a_prog_wait: assert property (p_prog_wait) else $error("wait cut short");

  property p_erase_pins;
    !EE_PINS_O.we_n && EE_PINS_O.erase_hv |-> !EE_PINS_O.ce_n && EE_PINS_O.oe_n;
  endproperty
  a_erase_pins: assert property (p_erase_pins) else $error("erase pin levels wrong");

  property p_erase_len;
    $past(state) == eepw_pkg::ST_ER_PULSE && state == eepw_pkg::ST_ER_HOLD
      |-> $past(cnt) == ER_PULS_CYC - 1'b1 ##1 EE_PINS_O.we_n && EE_PINS_O.erase_hv;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase pulse too short");

  property p_erase_setup;
    $rose(state == eepw_pkg::ST_ER_PULSE) |-> $past(cnt) == eepw_pkg::ER_SU_CYC - 1'b1;
  endproperty
  a_erase_setup: assert property (p_erase_setup) else $error("erase setup too short");

  c_read:  cover property (RSP_VALID_O);
  c_page:  cover property (take_more && nbytes == 7'h01);
  c_lock:  cover property (state == eepw_pkg::ST_GAP && page_set && seq_idx == 4'h2);
  c_erase: cover property ($rose(state == eepw_pkg::ST_ER_HOLD));

endmodule

// file: logic/eepw_pkg.sv
// Shared types, pin timing and command tables for the page-write EEPROM host controller
package eepw_pkg;

  localparam int CLK_NS = 8;
  localparam int CNT_W  = 21;

  // Pin timing, each figure in its own unit
  localparam int WP_NS      = 100;
  localparam int WPH_NS     = 50;
  localparam int RD_NS      = 120;
  localparam int DF_NS      = 50;
  localparam int WINDOW_US  = 150;
  localparam int PROG_MS    = 2;
  localparam int ER_SU_US   = 5;
  localparam int ER_PULS_MS = 10;

  localparam logic [CNT_W-1:0] WP_CYC  = CNT_W'((WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WPH_CYC = CNT_W'((WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'((RD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] DF_CYC  = CNT_W'((DF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] ER_SU_CYC =
    CNT_W'((ER_SU_US * 1000 + CLK_NS - 1) / CLK_NS);
  // Window is a latest time for the host, so it rounds down
  localparam logic [CNT_W-1:0] WINDOW_CYC = CNT_W'((WINDOW_US * 1000) / CLK_NS);
  localparam logic [CNT_W-1:0] PROG_CYC =
    CNT_W'((PROG_MS * 1000000 + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] ER_PULS_CYC =
    CNT_W'((ER_PULS_MS * 1000000 + CLK_NS - 1) / CLK_NS);

  localparam logic [6:0] PAGE_BYTES = 7'h40;

  // Command words {address, data}; values arbitrary, replace with the part's own
  localparam int SEQ_ON_FIRST  = 0;
  localparam int SEQ_OFF_FIRST = 3;
  localparam logic [3:0] SEQ_ON_LEN  = 4'h3;
  localparam logic [3:0] SEQ_OFF_LEN = 4'h6;
  localparam logic [20:0] SEQ_TAB [9] = '{
    21'h0_0101, 21'h0_0202, 21'h0_0303,
    21'h0_0404, 21'h0_0505, 21'h0_0606, 21'h0_0707, 21'h0_0808, 21'h0_0909};

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_LOCK_ON, OP_LOCK_OFF, OP_ERASE
  } eepw_op_e;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_WR_PULSE = 4'h1,
    ST_WR_HIGH  = 4'h3,
    ST_GAP      = 4'h2,
    ST_WAIT     = 4'h6,
    ST_READ     = 4'h7,
    ST_RD_FLOAT = 4'h5,
    ST_ER_SETUP = 4'h4,
    ST_ER_PULSE = 4'hC,
    ST_ER_HOLD  = 4'hD
  } eepw_state_e;

  typedef struct packed {
    eepw_op_e    op;
    logic [12:0] addr;
    logic [7:0]  data;
    logic        last;
  } eepw_req_s;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  dout;
    logic        dout_oe_n;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        erase_hv;
  } eepw_pins_s;

endpackage

// file: tb/eepw_dev_model.sv
// Behavioural page-write EEPROM that answers the host controller's pins
`timescale 1ns/1ns
module eepw_dev_model #(
  parameter int WIN  = 100,
  parameter int PROG = 20
) (
  // Clock used to time the load window and programming
  input  wire logic                 clk_i,
  // Host pins and returned data
  input  wire eepw_pkg::eepw_pins_s pins_i,
  output logic [7:0]                data_o
);
  logic [7:0]  mem [8192];
  logic [20:0] ld_q [$];
  logic [12:0] ad;
  logic [7:0]  last_b = 8'h00;
  logic [7:0]  last_o = 8'h00;
  logic        wr_q   = 1'b0;
  logic        rd_q   = 1'b0;
  logic        er_q   = 1'b0;
  logic        locked = 1'b0;
  logic        tog    = 1'b0;
  int          idle   = 0;
  int          prog   = 0;
  wire wr = !pins_i.ce_n && !pins_i.we_n && pins_i.oe_n && !pins_i.erase_hv;
  wire rd = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n && !pins_i.erase_hv;
  wire er = !pins_i.ce_n && !pins_i.we_n && pins_i.erase_hv;

  initial for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;

  function automatic logic match(input int first, input int len);
    if (ld_q.size() < len) return 1'b0;
    for (int i = 0; i < len; i++) if (ld_q[i] !== eepw_pkg::SEQ_TAB[first + i]) return 1'b0;
    return 1'b1;
  endfunction

  // Command bytes are never stored; a locked part still runs its timer
  task automatic commit();
    int skip;
    skip = match(eepw_pkg::SEQ_OFF_FIRST, 6) ? 6 : (match(eepw_pkg::SEQ_ON_FIRST, 3) ? 3 : 0);
    if (skip == 6) locked = 1'b0;
    if (skip == 3) locked = 1'b1;
    for (int i = skip; i < ld_q.size(); i++) begin
      if (!locked || skip > 0) mem[ld_q[i][20:8]] = ld_q[i][7:0];
      last_b = ld_q[i][7:0];
    end
    prog = PROG;
    ld_q.delete();
    idle = 0;
  endtask

  always @(posedge clk_i) begin
    if (wr && !wr_q) ad = pins_i.addr;
    if (!wr && wr_q && prog == 0) begin
      ld_q.push_back({ad, pins_i.dout});
      idle = 0;
    end
    if (prog > 0) prog--;
    if (ld_q.size() > 0) begin
      idle++;
      if (idle >= WIN) commit();
    end
    if (rd && !rd_q && prog > 0) tog = ~tog;
    if (er && !er_q) for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
    if (rd) last_o = data_o;
    wr_q = wr;
    rd_q = rd;
    er_q = er;
  end

  // Released bus shows the inverse of the last value, never a held copy
  always_comb begin
    if (rd && prog > 0) data_o = {~last_b[7], tog, last_b[5:0]};
    else if (rd) data_o = mem[pins_i.addr];
    else data_o = ~last_o;
  end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the page-write EEPROM host controller
`timescale 1ns/1ns
module testbench;
  localparam int WIN  = 100;
  localparam int PROG = 20;
  logic                 clk;
  logic                 rst;
  logic                 vld;
  eepw_pkg::eepw_req_s  req;
  logic                 rdy;
  logic                 rsp_v;
  logic [7:0]           rsp_d;
  logic                 busy;
  logic [7:0]           ee_d;
  eepw_pkg::eepw_pins_s pins;
  logic [7:0]           shadow [logic [12:0]];
  logic [6:0]           pg;
  logic                 pg_on = 1'b0;
  logic                 lk = 1'b0;
  int                   err_total = 0;
  int                   check_count = 0;
  eepw_pkg::eepw_op_e   ops [8] = '{eepw_pkg::OP_LOCK_ON, eepw_pkg::OP_WRITE,
    eepw_pkg::OP_LOCK_ON, eepw_pkg::OP_LOCK_OFF, eepw_pkg::OP_WRITE, eepw_pkg::OP_LOCK_ON,
    eepw_pkg::OP_LOCK_OFF, eepw_pkg::OP_WRITE};
  int                   lens [8] = '{0, 3, 64, 0, 3, 1, 1, 2};

  eepw_host #(
    .WINDOW_CYC  (eepw_pkg::CNT_W'(WIN)),
    .PROG_CYC    (eepw_pkg::CNT_W'(PROG)),
    .ER_PULS_CYC (eepw_pkg::CNT_W'(20))
  ) DUT (
    .CORE_CLK_I  (clk),
    .RST_I       (rst),
    .REQ_VALID_I (vld),
    .REQ_I       (req),
    .REQ_RDY_O   (rdy),
    .RSP_VALID_O (rsp_v),
    .RSP_DATA_O  (rsp_d),
    .BUSY_O      (busy),
    .EE_DATA_I   (ee_d),
    .EE_PINS_O   (pins)
  );

  eepw_dev_model #(.WIN(WIN), .PROG(PROG)) u_dev (.clk_i(clk), .pins_i(pins), .data_o(ee_d));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [12:0] a);
    return shadow.exists(a) ? shadow[a] : 8'hFF;
  endfunction

  // Holds the request until taken; leaves valid high so strobes never bounce
  task automatic send(input eepw_pkg::eepw_op_e op, input logic [12:0] a,
                      input logic [7:0] d, input logic l);
    int n;
    n = 0;
    vld = 1'b1;
    req = '{op: op, addr: a, data: d, last: l};
    #1;
    while (!rdy && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk(rdy, 1'b1);
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk(busy, 1'b0);
  endtask

  task automatic rd_chk(input logic [12:0] a);
    int n;
    n = 0;
    send(eepw_pkg::OP_READ, a, 8'h00, 1'b1);
    vld = 1'b0;
    while (!rsp_v && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(rsp_v, 1'b1);
    chk(rsp_d, exp_rd(a));
    wait_idle();
  endtask

  task automatic page(input eepw_pkg::eepw_op_e op, input logic [6:0] p, input int n);
    logic [7:0] d;
    if (op != eepw_pkg::OP_WRITE) send(op, 13'h0000, 8'h00, n == 0);
    if (op == eepw_pkg::OP_LOCK_ON) lk = 1'b1;
    if (op == eepw_pkg::OP_LOCK_OFF) lk = 1'b0;
    pg = p;
    pg_on = (op == eepw_pkg::OP_WRITE);
    for (int j = 0; j < n; j++) begin
      d = 8'($urandom);
      // Offer another page while the load waits: it must be refused
      if (j == 1 && op == eepw_pkg::OP_WRITE) begin
        req.addr = {~p, 6'h00};
        repeat (20) @(negedge clk);
        chk(rdy, 1'b0);
      end
      send(eepw_pkg::OP_WRITE, {p, 6'(j)}, d, j == n - 1);
      if (!lk || op != eepw_pkg::OP_WRITE) shadow[{p, 6'(j)}] = d;
    end
    vld = 1'b0;
    wait_idle();
    pg_on = 1'b0;
    if (n > 0) begin
      rd_chk({p, 6'h00});
      rd_chk({p, 6'(n - 1)});
    end
  endtask

  always @(posedge clk) if (!rst && !pins.ce_n && !pins.we_n) chk(pins.oe_n, 1'b1);
  always @(posedge clk) if (pg_on && !pins.ce_n && !pins.we_n) chk(pins.addr[12:6], pg);

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    err_total++;
    test_done();
  end

  initial begin
    logic [6:0] p;
    vld = 1'b0;
    req = '0;
    rst = 1'b1;
    void'($urandom(43));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk({pins.ce_n, pins.oe_n, pins.we_n, pins.dout_oe_n, pins.erase_hv, busy, rdy}, 7'h79);
    page(eepw_pkg::OP_WRITE, 7'h00, 1);
    page(eepw_pkg::OP_WRITE, 7'h7F, 1);
    page(eepw_pkg::OP_WRITE, 7'($urandom), 64);
    page(eepw_pkg::OP_WRITE, 7'($urandom), int'($urandom_range(63, 2)));
    p = 7'($urandom);
    for (int k = 0; k < 8; k++) page(ops[k], p, lens[k]);
    send(eepw_pkg::OP_ERASE, 13'h0000, 8'h00, 1'b1);
    vld = 1'b0;
    wait_idle();
    shadow.delete();
    rd_chk({p, 6'h00});
    test_done();
  end
endmodule
